//--- hw/upgrade_seq_defs.vh
// Constants for the remote upgrade sequencer and watchdog
`ifndef UPGRADE_SEQ_DEFS_VH
`define UPGRADE_SEQ_DEFS_VH
`define CFG_WIDTH 21
`define STAT_WIDTH 5
`define SHIFT_WIDTH 26
`define CFG_APP_BIT 0
`define CFG_PAGE_LSB 1
`define CFG_PAGE_MSB 7
`define CFG_WDEN_BIT 8
`define CFG_WDVAL_LSB 9
`define CFG_WDVAL_MSB 20
`define CFG_RESET_VALUE 21'h000000
`define LOCAL_PAGE 7'h01
`define STAT_CRC_BIT 0
`define STAT_PIN_BIT 1
`define STAT_CORE_BIT 2
`define STAT_EXT_BIT 3
`define STAT_WD_BIT 4
`define WD_WIDTH 29
`define WD_ZERO_FILL 17
`define OSC_PERIOD_NS 100
`define CLK_PERIOD_NS 4
`define OSC_DIV ((`OSC_PERIOD_NS) / (`CLK_PERIOD_NS))
`define LOAD_CYCLES 8
`define ADDR_CONTROL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_UPDATE 4'h8
`define ADDR_MODE 4'hC
`endif

//--- hw/upgrade_sequencer.v
// Remote configuration-upgrade sequencer with user watchdog
`timescale 1ns/100ps
`include "upgrade_seq_defs.vh"
module upgrade_sequencer
#(
  parameter OSC_DIV = `OSC_DIV,
  parameter LOAD_CYCLES = `LOAD_CYCLES
)
(
  input wire i_clock,
  input wire i_rst_b,
  input wire i_upgrade_shift_clock,
  input wire i_shift_not_load_select,
  input wire i_capture_not_update_select,
  input wire i_shift_data,
  input wire i_logic_reconfig_request_line_n,
  input wire i_watchdog_restart_n,
  input wire i_status_error_pin_n,
  input wire i_crc_error,
  input wire i_ext_reconfig_n,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  output reg o_shift_data,
  output reg o_user_mode,
  output reg o_app_image,
  output reg o_watchdog_timeout
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers: three flops; selects and data use stage three alone, other lines count a change when stages two and three agree
reg [2:0] clk_sync_reg;
reg [2:0] shift_sel_sync_reg;
reg [2:0] capt_sel_sync_reg;
reg [2:0] sdata_sync_reg;
reg [2:0] req_sync_reg;
reg [2:0] rst_sync_reg;
reg [2:0] pin_sync_reg;
reg [2:0] crc_sync_reg;
reg [2:0] ext_sync_reg;
reg clk_lvl_reg;
reg req_lvl_reg;
reg rst_lvl_reg;
reg pin_lvl_reg;
reg crc_lvl_reg;
reg ext_lvl_reg;

function settled;
  input [2:0] s;
  input prev;
  begin
    settled = (s[1] == s[2]) ? s[2] : prev;
  end
endfunction

always @(posedge i_clock or negedge i_rst_b)
begin
  if (!i_rst_b)
  begin
    clk_sync_reg <= 3'h0;
    shift_sel_sync_reg <= 3'h0;
    capt_sel_sync_reg <= 3'h0;
    sdata_sync_reg <= 3'h0;
    req_sync_reg <= 3'h7;
    rst_sync_reg <= 3'h7;
    pin_sync_reg <= 3'h7;
    crc_sync_reg <= 3'h0;
    ext_sync_reg <= 3'h7;
    clk_lvl_reg <= 1'b0;
    req_lvl_reg <= 1'b1;
    rst_lvl_reg <= 1'b1;
    pin_lvl_reg <= 1'b1;
    crc_lvl_reg <= 1'b0;
    ext_lvl_reg <= 1'b1;
  end
  else
  begin
    clk_sync_reg <= {clk_sync_reg[1:0], i_upgrade_shift_clock};
    shift_sel_sync_reg <= {shift_sel_sync_reg[1:0], i_shift_not_load_select};
    capt_sel_sync_reg <= {capt_sel_sync_reg[1:0], i_capture_not_update_select};
    sdata_sync_reg <= {sdata_sync_reg[1:0], i_shift_data};
    req_sync_reg <= {req_sync_reg[1:0], i_logic_reconfig_request_line_n};
    rst_sync_reg <= {rst_sync_reg[1:0], i_watchdog_restart_n};
    pin_sync_reg <= {pin_sync_reg[1:0], i_status_error_pin_n};
    crc_sync_reg <= {crc_sync_reg[1:0], i_crc_error};
    ext_sync_reg <= {ext_sync_reg[1:0], i_ext_reconfig_n};
    clk_lvl_reg <= settled(clk_sync_reg, clk_lvl_reg);
    req_lvl_reg <= settled(req_sync_reg, req_lvl_reg);
    rst_lvl_reg <= settled(rst_sync_reg, rst_lvl_reg);
    pin_lvl_reg <= settled(pin_sync_reg, pin_lvl_reg);
    crc_lvl_reg <= settled(crc_sync_reg, crc_lvl_reg);
    ext_lvl_reg <= settled(ext_sync_reg, ext_lvl_reg);
  end
end

wire clk_next = settled(clk_sync_reg, clk_lvl_reg);
wire shift_edge = clk_next & ~clk_lvl_reg;
wire req_rise = settled(req_sync_reg, req_lvl_reg) & ~req_lvl_reg;
wire restart_fall = ~settled(rst_sync_reg, rst_lvl_reg) & rst_lvl_reg;
wire pin_fall = ~settled(pin_sync_reg, pin_lvl_reg) & pin_lvl_reg;
wire crc_rise = settled(crc_sync_reg, crc_lvl_reg) & ~crc_lvl_reg;
wire ext_fall = ~settled(ext_sync_reg, ext_lvl_reg) & ext_lvl_reg;

////////////////////////////////////////////////////////////////////////////////
// Oscillator tick divider: watchdog runs at the internal oscillator rate
reg [7:0] div_reg;
wire osc_tick = (div_reg == 8'h00);

always @(posedge i_clock or negedge i_rst_b)
begin
  if (!i_rst_b)
    div_reg <= 8'h00;
  else if (osc_tick)
    div_reg <= OSC_DIV[7:0] - 8'h01;
  else
    div_reg <= div_reg - 8'h01;
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer
localparam ST_USER = 2'h0;
localparam ST_CONFIG = 2'h1;

reg [1:0] state_reg;
reg [15:0] load_cnt_reg;
reg [`CFG_WIDTH-1:0] control_reg;
reg [`CFG_WIDTH-1:0] update_reg;
reg [`STAT_WIDTH-1:0] status_reg;
reg [`SHIFT_WIDTH-1:0] shift_reg;
reg [`WD_WIDTH-1:0] wd_count_reg;
reg local_mode_reg;
reg wd_expire;

wire app_image = control_reg[`CFG_APP_BIT];
wire factory_remote = ~app_image & ~local_mode_reg;
wire wd_running = (state_reg == ST_USER) & app_image & ~local_mode_reg &
  control_reg[`CFG_WDEN_BIT];
wire [`WD_WIDTH-1:0] wd_reload =
  {control_reg[`CFG_WDVAL_MSB:`CFG_WDVAL_LSB], {`WD_ZERO_FILL{1'b0}}};

// Error events outrank a logic-array request when they coincide
wire err_event = pin_fall | crc_rise | wd_expire;
wire any_event = err_event | ext_fall | req_rise;

always @*
begin
  wd_expire = wd_running & osc_tick & (wd_count_reg == {`WD_WIDTH{1'b0}});
end

always @(posedge i_clock or negedge i_rst_b)
begin
  if (!i_rst_b)
  begin
    state_reg <= ST_CONFIG;
    load_cnt_reg <= 16'h0000;
    control_reg <= `CFG_RESET_VALUE;
    status_reg <= {`STAT_WIDTH{1'b0}};
    wd_count_reg <= {`WD_WIDTH{1'b0}};
  end
  else
  begin
    if (any_event)
    begin
      state_reg <= ST_CONFIG;
      load_cnt_reg <= LOAD_CYCLES[15:0];
      // Status captured before the next image starts loading
      status_reg <= {wd_expire, ext_fall, req_rise & ~err_event & ~ext_fall,
        pin_fall, crc_rise};
      if (err_event)
        control_reg <= {`CFG_WIDTH{1'b0}};
      else if (local_mode_reg)
        control_reg <= {{(`CFG_WIDTH-8){1'b0}}, `LOCAL_PAGE, 1'b1};
      else if (ext_fall)
        control_reg <= {`CFG_WIDTH{1'b0}};
      else if (app_image)
        control_reg <= {`CFG_WIDTH{1'b0}}; // Application request falls back
      else
        control_reg <= update_reg;
    end
    else
    begin
      case (state_reg)
        ST_CONFIG:
        begin
          if (load_cnt_reg == 16'h0000)
          begin
            state_reg <= ST_USER;
            wd_count_reg <= wd_reload;
          end
          else
            load_cnt_reg <= load_cnt_reg - 16'h0001;
        end
        ST_USER:
        begin
          if (!wd_running)
            wd_count_reg <= wd_reload;
          else if (restart_fall)
            wd_count_reg <= wd_reload;
          else if (osc_tick)
            wd_count_reg <= wd_count_reg - {{(`WD_WIDTH-1){1'b0}}, 1'b1};
        end
        default:
          state_reg <= ST_CONFIG;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Shift and update path, stepped on synchronised shift-clock rising edges
always @(posedge i_clock or negedge i_rst_b)
begin
  if (!i_rst_b)
  begin
    shift_reg <= {`SHIFT_WIDTH{1'b0}};
    update_reg <= {`CFG_WIDTH{1'b0}};
  end
  else if (shift_edge)
  begin
    if (shift_sel_sync_reg[2])
      shift_reg <= {shift_reg[`SHIFT_WIDTH-2:0], sdata_sync_reg[2]};
    else if (capt_sel_sync_reg[2])
      shift_reg <= {status_reg, app_image ? control_reg : update_reg};
    else if (factory_remote)
      update_reg <= shift_reg[`CFG_WIDTH-1:0];
  end
end

////////////////////////////////////////////////////////////////////////////////
// Avalon-MM slave: one wait cycle, answer on the second edge
reg avs_busy_reg;
function [31:0] reg_read;
  input [3:0] a;
  begin
    case (a)
      `ADDR_CONTROL: reg_read = {11'h000, control_reg};
      `ADDR_STATUS: reg_read = {27'h0000000, status_reg};
      `ADDR_UPDATE: reg_read = {11'h000, app_image ? control_reg : update_reg};
      `ADDR_MODE: reg_read = {31'h00000000, local_mode_reg};
      default: reg_read = 32'h00000000;
    endcase
  end
endfunction

always @(posedge i_clock or negedge i_rst_b)
begin
  if (!i_rst_b)
  begin
    avs_busy_reg <= 1'b0;
    o_avs_waitrequest <= 1'b1;
    o_avs_readdata <= 32'h00000000;
    local_mode_reg <= 1'b0;
    o_shift_data <= 1'b0;
    o_user_mode <= 1'b0;
    o_app_image <= 1'b0;
    o_watchdog_timeout <= 1'b0;
  end
  else
  begin
    o_shift_data <= shift_reg[`SHIFT_WIDTH-1];
    o_user_mode <= (state_reg == ST_USER);
    o_app_image <= app_image;
    o_watchdog_timeout <= wd_expire;
    if ((i_avs_read || i_avs_write) && !avs_busy_reg)
    begin
      avs_busy_reg <= 1'b1;
      o_avs_waitrequest <= 1'b0;
      if (i_avs_read)
        o_avs_readdata <= reg_read(i_avs_address);
      // Mode is a boot strap; only the factory image may change it
      if (i_avs_write && i_avs_address == `ADDR_MODE && !app_image)
        local_mode_reg <= i_avs_writedata[0];
    end
    else
    begin
      avs_busy_reg <= 1'b0;
      o_avs_waitrequest <= 1'b1;
    end
  end
end

endmodule

//--- tb/upgrade_sequencer_assertions.sv
// Port checker for the upgrade sequencer
`timescale 1ns/100ps
module upgrade_sequencer_checker
#(
  parameter OSC_DIV = 25,
  parameter LOAD_CYCLES = 8
)
(
  input wire i_clock,
  input wire i_rst_b,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire i_crc_error,
  input wire i_status_error_pin_n,
  input wire i_logic_reconfig_request_line_n,
  input wire o_avs_waitrequest,
  input wire o_user_mode,
  input wire o_app_image,
  input wire o_watchdog_timeout
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////////
  sequence s_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  // Sync chain plus reload settles well inside twelve cycles
  sequence s_fallback;
    ##[1:12] !o_app_image;
  endsequence
  property p_answer;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> s_answer;
  endproperty
  property p_idle;
    !(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  property p_wd_ctx;
    o_watchdog_timeout |-> o_app_image && o_user_mode;
  endproperty
  property p_wd_pulse;
    o_watchdog_timeout |=> !o_watchdog_timeout;
  endproperty
  property p_wd_drop;
    o_watchdog_timeout |-> s_fallback;
  endproperty
  property p_crc;
    $rose(i_crc_error) |-> s_fallback;
  endproperty
  property p_pin;
    $fell(i_status_error_pin_n) |-> s_fallback;
  endproperty
  property p_sync;
    $rose(i_logic_reconfig_request_line_n) |=> $stable(o_app_image) [*2];
  endproperty
  property p_cfg_len;
    $rose(o_user_mode) |-> !$past(o_user_mode, 8);
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  a_idle: assert property (p_idle) else $error("answer without request");
  a_wd_ctx: assert property (p_wd_ctx) else $error("expiry outside app");
  a_wd_pulse: assert property (p_wd_pulse) else $error("expiry not a pulse");
  a_wd_drop: assert property (p_wd_drop) else $error("no fallback on expiry");
  a_crc: assert property (p_crc) else $error("no fallback on crc");
  a_pin: assert property (p_pin) else $error("no fallback on pin");
  a_sync: assert property (p_sync) else $error("request not synchronised");
  a_cfg_len: assert property (p_cfg_len) else $error("config too short");
endmodule
bind upgrade_sequencer upgrade_sequencer_checker
#(.OSC_DIV(OSC_DIV), .LOAD_CYCLES(LOAD_CYCLES)) chk
(
  .i_clock, .i_rst_b, .i_avs_read, .i_avs_write, .i_crc_error, .i_status_error_pin_n,
  .i_logic_reconfig_request_line_n, .o_avs_waitrequest, .o_user_mode, .o_app_image,
  .o_watchdog_timeout
);

//--- tb/user_logic_model.sv
// Behavioural user logic on the upgrade shift port
`timescale 1ns/100ps
module user_logic_model
(
  input wire i_clock,
  input wire i_data,
  output reg o_sclk,
  output reg o_ssel,
  output reg o_csel,
  output reg o_data,
  output reg o_req_n,
  output reg o_rst_n
);
  integer i;
  initial
  begin
    {o_sclk, o_ssel, o_csel, o_data, o_req_n, o_rst_n} = 6'h1F;
  end
  // Link clock runs only inside a frame, so selects hold 20 clocks each side
  task tick;
    begin
      repeat (20) @(posedge i_clock);
      o_sclk <= 1'b1;
      repeat (20) @(posedge i_clock);
      o_sclk <= 1'b0;
    end
  endtask
  task send_word(input [20:0] w);
    begin
      for (i = 20; i >= 0; i = i - 1)
      begin
        o_ssel <= 1'b1;
        o_data <= w[i];
        tick;
      end
      {o_ssel, o_csel} <= 2'h0;
      o_data <= ~w[0];
      tick;
      o_csel <= 1'b1;
    end
  endtask
  // Capture edge first, then 25 shifts; the MSB is read after the capture and after each shift
  task read_word(output [25:0] q);
    begin
      {o_ssel, o_csel} <= 2'h1;
      tick;
      q[25] = i_data;
      for (i = 24; i >= 0; i = i - 1)
      begin
        o_ssel <= 1'b1;
        tick;
        q[i] = i_data;
      end
    end
  endtask
  task kick;
    begin
      @(posedge i_clock);
      o_rst_n <= 1'b0;
      repeat (8) @(posedge i_clock);
      o_rst_n <= 1'b1;
    end
  endtask
  task request;
    begin
      @(posedge i_clock);
      o_req_n <= 1'b0;
      repeat (8) @(posedge i_clock);
      o_req_n <= 1'b1;
    end
  endtask
endmodule

//--- tb/upgrade_sequencer_tb.sv
// Self-checking bench for the upgrade sequencer
`timescale 1ns/100ps
module upgrade_sequencer_tb;
  reg clk, rst_b, rd, wr, crc, pin_n, ext_n;
  reg [3:0] addr;
  reg [31:0] wdata, rq;
  reg [25:0] cap;
  wire [31:0] rdata;
  wire wait_req, sdo, umode, app, wdt, sclk, ssel, csel, sdi, req_n, wdr_n;
  integer err_total, checks;
  localparam [31:0] W1 = 32'h0015790B;
  upgrade_sequencer #(.OSC_DIV(2), .LOAD_CYCLES(8)) dut
  (
    .i_clock(clk), .i_rst_b(rst_b), .i_upgrade_shift_clock(sclk),
    .i_shift_not_load_select(ssel), .i_capture_not_update_select(csel),
    .i_shift_data(sdi), .i_logic_reconfig_request_line_n(req_n),
    .i_watchdog_restart_n(wdr_n), .i_status_error_pin_n(pin_n), .i_crc_error(crc),
    .i_ext_reconfig_n(ext_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
    .o_shift_data(sdo), .o_user_mode(umode), .o_app_image(app), .o_watchdog_timeout(wdt)
  );
  user_logic_model ul
  (
    .i_clock(clk), .i_data(sdo), .o_sclk(sclk), .o_ssel(ssel), .o_csel(csel), .o_data(sdi),
    .o_req_n(req_n), .o_rst_n(wdr_n)
  );
  ////////////////////////////////////////////////////////////////
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp)
      begin
        err_total = err_total + 1;
        $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      while (wait_req !== 1'b0)
        @(posedge clk);
      rq = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task rd_chk(input [3:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      check(rq, e);
    end
  endtask
  task stat_bit(input integer b);
    begin
      bus(1'b0, 4'h4, 32'h0);
      check(rq, 32'h00000001 << b);
    end
  endtask
  // Kind 0 crc, 1 status pin, 2 external reset; long tail lets reload finish
  task pulse(input integer k);
    begin
      crc <= (k == 0);
      pin_n <= (k != 1);
      ext_n <= (k != 2);
      repeat (8) @(posedge clk);
      {crc, pin_n, ext_n} <= 3'h3;
      repeat (24) @(posedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_factory;
    begin
      rd_chk(4'h2, 32'h0);
      bus(1'b1, 4'h0, 32'h1FFFFF);
      rd_chk(4'h0, 32'h0);
      ul.send_word(W1[20:0]);
      rd_chk(4'h8, W1);
      ul.read_word(cap);
      check({6'h00, cap}, {11'h000, W1[20:0]});
      ul.request;
      repeat (24) @(posedge clk);
      check({31'h0, app}, 32'h1);
      check({31'h0, umode}, 32'h1);
      rd_chk(4'h0, W1);
      ul.kick;
      repeat (8) @(posedge clk);
      check({31'h0, app}, 32'h1);
      ul.send_word(21'h1FFFFE);
      rd_chk(4'h8, W1);
    end
  endtask
  task t_errors;
    begin
      pulse(0);
      rd_chk(4'h0, 32'h0);
      stat_bit(0);
      rd_chk(4'h8, W1);
      pulse(2);
      rd_chk(4'h0, 32'h0);
      stat_bit(3);
    end
  endtask
  task t_wd;
    integer n;
    begin
      ul.send_word(21'h000105);
      ul.request;
      n = 0;
      while (wdt !== 1'b1 && n < 400)
      begin
        @(posedge clk);
        n = n + 1;
      end
      check({31'h0, wdt}, 32'h1);
      repeat (24) @(posedge clk);
      rd_chk(4'h0, 32'h0);
      stat_bit(4);
      ul.read_word(cap);
      check({6'h00, cap}, {6'h00, 5'h10, 21'h000105});
    end
  endtask
  task t_local;
    begin
      bus(1'b1, 4'hC, 32'h1);
      rd_chk(4'hC, 32'h1);
      pulse(2);
      rd_chk(4'h0, 32'h3);
      pulse(1);
      rd_chk(4'h0, 32'h0);
      stat_bit(1);
      ul.request;
      repeat (24) @(posedge clk);
      rd_chk(4'h0, 32'h3);
      stat_bit(2);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {rst_b, rd, wr, crc, pin_n, ext_n} = 6'h3;
    {addr, wdata, rq, err_total, checks} = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_factory;
    t_errors;
    t_wd;
    t_local;
    wrap_up;
  end
  // Whole run needs about 5000 clocks
  initial
  begin
    #200000;
    err_total = err_total + 1;
    wrap_up;
  end
endmodule
